// ### rtl/rps_pkg.sv
// Purpose: shared constants and types of the receiver mode and polling sequencer
// Assumes: registers are written and read through a byte-wide strobe port on ref_clk
// Notes: all offsets, reset values and timing counts live here
package rps_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CHIP_MODE_CONTROL_0 = 8'h02;
    localparam logic [7:0] ADDR_ACTUAL_RF_CHANNEL = 8'h06;
    localparam logic [7:0] ADDR_CONFIG_A_MODULATION_TYPE = 8'h21;
    localparam logic [7:0] ADDR_CONFIG_A_CHANNEL1_PLL = 8'h22;
    localparam logic [7:0] ADDR_CONFIG_B_MODULATION_TYPE = 8'h42;
    localparam logic [7:0] ADDR_CONFIG_B_CHANNEL1_PLL = 8'h43;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_CHIP_MODE_CONTROL_0 = 8'h40;
    localparam logic [7:0] RST_ACTUAL_RF_CHANNEL = 8'h00;
    localparam logic [7:0] RST_MODULATION_TYPE = 8'h04;
    localparam logic [4:0] RST_CHANNEL1_PLL = 5'h09;
    localparam logic [4:0] RST_CHANNEL2_PLL = 5'h08;
    localparam logic [4:0] RST_CHANNEL3_PLL = 5'h0A;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int BIT_OPERATING_MODE_SELECT = 0;
    localparam int BIT_SLAVE_RECEIVER_ENABLE = 1;
    localparam int BIT_DUAL_CONFIG_ENABLE = 2;
    localparam int CHANNEL_COUNT_LSB = 2;
    localparam int MODULATION_TYPE_LSB = 0;
    localparam int PLL_SETTING_WIDTH = 5;

    // ------------------------------------------------------------
    // timing: pll settling before each wake-up search
    // ------------------------------------------------------------
    localparam int CLOCK_PERIOD_PS = 4000;
    localparam int SETTLE_TIME_US = 40;
    localparam int SETTLE_CYCLES = (SETTLE_TIME_US * 1000000) / CLOCK_PERIOD_PS;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic en;
        logic [7:0] addr;
        logic [7:0] data;
    } rps_reg_wr_t;

    typedef struct packed {
        logic rf_enable;
        logic osc_high_precision;
        logic startup_req;
        logic search_active;
        logic slave_run;
        logic run_self_polling;
    } rps_rx_ctrl_t;

    typedef struct packed {
        logic load;
        logic cfg_b;
        logic [PLL_SETTING_WIDTH-1:0] setting;
    } rps_pll_cmd_t;

    typedef enum logic [3:0] {
        ST_SLEEP = 4'h0,
        ST_SLAVE_WAIT = 4'h1,
        ST_SLAVE_RUN = 4'h2,
        ST_SP_IDLE = 4'h3,
        ST_SP_WAIT = 4'h4,
        ST_INIT_LOOP = 4'h5,
        ST_MOD_SWITCH = 4'h6,
        ST_INIT_CFG = 4'h7,
        ST_LOAD_CH = 4'h8,
        ST_SETTLE = 4'h9,
        ST_SEARCH = 4'hA,
        ST_STORE = 4'hB,
        ST_COMPARE = 4'hC,
        ST_INCR = 4'hD,
        ST_RUN_SP = 4'hE
    } rps_state_t;

endpackage

// ### rtl/rps_sequencer.sv
// Purpose: operating mode control and self polling scan sequencer of the receiver
// Assumes: rx_run, startup_done and wake-up results come from logic on ref_clk
// Notes: channel settle wait is counted on ref_clk, shortenable by parameter
`timescale 1ns/1ps

// Behaviour
// R1 - sleep turns rf section off and oscillator to low precision; writes still accepted
// R2 - leaving sleep for slave run first waits for the start-up sequence
// R3 - with mode select 0, slave enable 0 gives sleep, 1 gives slave run
// R4 - mode select bit 0 chooses slave/sleep (0) or self polling (1)
// R5 - wake-up found in self polling hands over to run mode self polling
// R6 - host reconfigures self polling only via sleep and back
// R7 - polling timer paces scans; sequencer switches between config sets A and B
// R8 - up to three channels are scanned in turn per config set
// R9 - dual config bit: 0 scans A only, 1 scans A then B
// R10 - modulation bits 3:2 give channel count 1..3; slave uses one channel
// R11 - single configuration always takes settings from config A
// R12 - idle until receiver-run enable, then wait for start-up to finish
// R13 - loop counter starts at channel 1 of A and selects the channel
// R14 - set modulation type, then initialise receiver with config settings
// R15 - load channel 1 pll setting, wait about 40 us before searching
// R16 - run chosen wake-up search; success stores channel, failure compares
// R17 - on success write selected channel to actual channel register
// R18 - at count end go idle or start config B loop, else increment
// R19 - after increment load channel 2 or 3 pll and wait before search
// R20 - modulation changes automatically after wake-up per modulation type bits
// R21 - host enters slave run by writing mode select 0, slave enable 1
// R22 - config B loop mirrors A with B settings, then returns to idle
// R23 - two-bit loop counter counts 1..3, never above the channel count
module rps_sequencer #(
    parameter int SETTLE_CYCLES_P = rps_pkg::SETTLE_CYCLES
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire rps_pkg::rps_reg_wr_t reg_wr,
    input wire logic rd_en,
    input wire logic [7:0] rd_addr,
    output logic [7:0] rd_data,
    input wire logic rx_run,
    input wire logic startup_done,
    input wire logic [1:0] polling_scheme_select,
    input wire logic permanent_wakeup_search_enable,
    input wire logic wakeup_found,
    input wire logic wakeup_miss,
    output rps_pkg::rps_rx_ctrl_t rx_ctrl,
    output rps_pkg::rps_pll_cmd_t pll_cmd,
    output logic cfg_init,
    output logic modulation_fsk,
    output logic [2:0] search_scheme
);
    import rps_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // scan column differs from run column for codes 10b and 11b
    function automatic logic mod_is_fsk(input logic [1:0] mt, input logic run_col);
        mod_is_fsk = run_col ? mt[0] : (mt[0] ^ mt[1]);
    endfunction

    // a zero channel count is treated as one so the loop always ends
    function automatic logic [1:0] eff_count(input logic [7:0] mt_reg);
        logic [1:0] c;
        c = mt_reg[CHANNEL_COUNT_LSB +: 2];
        eff_count = (c == 2'h0) ? 2'h1 : c;
    endfunction

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] chip_mode_control_0;
    logic [7:0] actual_rf_channel;
    logic [7:0] config_a_modulation_type;
    logic [7:0] config_b_modulation_type;
    logic [PLL_SETTING_WIDTH-1:0] pll_table [0:1][0:2];
    rps_state_t state;
    rps_state_t next_state;
    logic cfg_b;
    logic [1:0] loop_cnt;
    logic [13:0] settle_cnt;

    wire operating_mode_select = chip_mode_control_0[BIT_OPERATING_MODE_SELECT];
    wire slave_receiver_enable = chip_mode_control_0[BIT_SLAVE_RECEIVER_ENABLE];
    wire dual_config_enable = chip_mode_control_0[BIT_DUAL_CONFIG_ENABLE];
    // R11 config select
    wire [7:0] cur_mt_reg = cfg_b ? config_b_modulation_type : config_a_modulation_type;
    wire [1:0] modulation_type = cur_mt_reg[MODULATION_TYPE_LSB +: 2];
    // R10 channel count
    wire [1:0] channel_count = eff_count(cur_mt_reg);
    wire [1:0] loop_idx = loop_cnt - 2'h1;
    wire [PLL_SETTING_WIDTH-1:0] cur_pll = pll_table[cfg_b][loop_idx];
    wire wr_pll_a = reg_wr.en && reg_wr.addr >= ADDR_CONFIG_A_CHANNEL1_PLL
        && reg_wr.addr <= ADDR_CONFIG_A_CHANNEL1_PLL + 8'h02;
    wire wr_pll_b = reg_wr.en && reg_wr.addr >= ADDR_CONFIG_B_CHANNEL1_PLL
        && reg_wr.addr <= ADDR_CONFIG_B_CHANNEL1_PLL + 8'h02;
    wire [1:0] wr_pll_idx = wr_pll_a ? 2'(reg_wr.addr - ADDR_CONFIG_A_CHANNEL1_PLL)
        : 2'(reg_wr.addr - ADDR_CONFIG_B_CHANNEL1_PLL);
    wire in_scan = state inside {ST_SP_IDLE, ST_SP_WAIT, ST_INIT_LOOP, ST_MOD_SWITCH,
        ST_INIT_CFG, ST_LOAD_CH, ST_SETTLE, ST_SEARCH, ST_STORE, ST_COMPARE, ST_INCR,
        ST_RUN_SP};
    wire at_last = loop_cnt >= channel_count;

    // ------------------------------------------------------------
    // register writes; accepted in every state, sleep included
    // ------------------------------------------------------------
    // R1 writes in sleep
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            chip_mode_control_0 <= RST_CHIP_MODE_CONTROL_0;
            config_a_modulation_type <= RST_MODULATION_TYPE;
            config_b_modulation_type <= RST_MODULATION_TYPE;
        end else if (reg_wr.en) begin
            if (reg_wr.addr == ADDR_CHIP_MODE_CONTROL_0) begin
                chip_mode_control_0 <= reg_wr.data;
            end
            if (reg_wr.addr == ADDR_CONFIG_A_MODULATION_TYPE) begin
                config_a_modulation_type <= reg_wr.data;
            end
            if (reg_wr.addr == ADDR_CONFIG_B_MODULATION_TYPE) begin
                config_b_modulation_type <= reg_wr.data;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            for (int c = 0; c < 2; c++) begin
                pll_table[c][0] <= RST_CHANNEL1_PLL;
                pll_table[c][1] <= RST_CHANNEL2_PLL;
                pll_table[c][2] <= RST_CHANNEL3_PLL;
            end
        end else if (wr_pll_a || wr_pll_b) begin
            pll_table[wr_pll_b][wr_pll_idx] <= reg_wr.data[PLL_SETTING_WIDTH-1:0];
        end
    end

    // only the actual channel register reads back; write-only ones read zero
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rd_data <= 8'h00;
        end else if (rd_en) begin
            rd_data <= (rd_addr == ADDR_ACTUAL_RF_CHANNEL) ? actual_rf_channel : 8'h00;
        end
    end

    // ------------------------------------------------------------
    // mode and scan state machine
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        if (!operating_mode_select) begin
            // R3 sleep or slave run
            if (!slave_receiver_enable) begin
                next_state = ST_SLEEP;
            end else if (state == ST_SLEEP || in_scan) begin
                // R2 start-up first
                next_state = ST_SLAVE_WAIT;
            end else if (state == ST_SLAVE_WAIT && startup_done) begin
                next_state = ST_SLAVE_RUN;
            end
        end else if (!in_scan) begin
            // R4 self polling
            next_state = ST_SP_IDLE;
        end else begin
            case (state)
                // R12 idle and start-up
                ST_SP_IDLE: next_state = rx_run ? ST_SP_WAIT : ST_SP_IDLE;
                ST_SP_WAIT: next_state = startup_done ? ST_INIT_LOOP : ST_SP_WAIT;
                ST_INIT_LOOP: next_state = ST_MOD_SWITCH;
                ST_MOD_SWITCH: next_state = ST_INIT_CFG;
                ST_INIT_CFG: next_state = ST_LOAD_CH;
                ST_LOAD_CH: next_state = ST_SETTLE;
                ST_SETTLE: next_state = (settle_cnt == 14'h0000) ? ST_SEARCH : ST_SETTLE;
                // R16 search outcome
                ST_SEARCH: begin
                    if (wakeup_found) begin
                        next_state = ST_STORE;
                    end else if (wakeup_miss) begin
                        next_state = ST_COMPARE;
                    end
                end
                // R5 hand over
                ST_STORE: next_state = ST_RUN_SP;
                // R18 R9 R22 loop end
                ST_COMPARE: begin
                    if (!at_last) begin
                        next_state = ST_INCR;
                    end else if (dual_config_enable && !cfg_b) begin
                        next_state = ST_INIT_LOOP;
                    end else begin
                        next_state = ST_SP_IDLE;
                    end
                end
                ST_INCR: next_state = ST_LOAD_CH;
                ST_RUN_SP: next_state = ST_RUN_SP;
                default: next_state = ST_SP_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state <= ST_SLEEP;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // loop counter, config select, settle timer
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cfg_b <= 1'b0;
            loop_cnt <= 2'h1;
        end else if (state == ST_SP_WAIT) begin
            cfg_b <= 1'b0;
        end else if (state == ST_INIT_LOOP) begin
            // R13 R23 restart at channel 1
            loop_cnt <= 2'h1;
        end else if (state == ST_COMPARE && at_last && dual_config_enable) begin
            // R7 R22 switch to config B
            cfg_b <= 1'b1;
        end else if (state == ST_INCR) begin
            // R8 R23 next channel
            loop_cnt <= loop_cnt + 2'h1;
        end
    end

    // R15 R19 settle wait
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            settle_cnt <= 14'h0000;
        end else if (state == ST_LOAD_CH) begin
            settle_cnt <= 14'(SETTLE_CYCLES_P - 1);
        end else if (state == ST_SETTLE && settle_cnt != 14'h0000) begin
            settle_cnt <= settle_cnt - 14'h0001;
        end
    end

    // ------------------------------------------------------------
    // receiver commands
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pll_cmd <= '0;
            cfg_init <= 1'b0;
            modulation_fsk <= 1'b0;
            search_scheme <= 3'h0;
            actual_rf_channel <= RST_ACTUAL_RF_CHANNEL;
        end else begin
            pll_cmd.load <= 1'b0;
            cfg_init <= 1'b0;
            if (state == ST_MOD_SWITCH) begin
                // R14 scan modulation
                modulation_fsk <= mod_is_fsk(modulation_type, 1'b0);
            end
            if (state == ST_INIT_CFG) begin
                // R14 init with config
                cfg_init <= 1'b1;
            end
            if (state == ST_LOAD_CH) begin
                // R15 R19 channel pll load
                pll_cmd <= '{load: 1'b1, cfg_b: cfg_b, setting: cur_pll};
            end
            if (state == ST_SETTLE) begin
                // R16 latch search scheme
                search_scheme <= {permanent_wakeup_search_enable, polling_scheme_select};
            end
            if (state == ST_STORE) begin
                // R17 store channel
                actual_rf_channel <= {6'h00, loop_cnt};
                // R20 run column modulation
                modulation_fsk <= mod_is_fsk(modulation_type, 1'b1);
            end
            if (state == ST_SLAVE_WAIT && next_state == ST_SLAVE_RUN) begin
                // R10 slave uses channel 1 of A
                modulation_fsk <= config_a_modulation_type[MODULATION_TYPE_LSB];
                pll_cmd <= '{load: 1'b1, cfg_b: 1'b0, setting: pll_table[0][0]};
            end
        end
    end

    // R1 sleep power state
    assign rx_ctrl.rf_enable = !(state inside {ST_SLEEP, ST_SP_IDLE});
    assign rx_ctrl.osc_high_precision = (state != ST_SLEEP);
    assign rx_ctrl.startup_req = state inside {ST_SLAVE_WAIT, ST_SP_WAIT};
    assign rx_ctrl.search_active = (state == ST_SEARCH);
    assign rx_ctrl.slave_run = (state == ST_SLAVE_RUN);
    assign rx_ctrl.run_self_polling = (state == ST_RUN_SP);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_sleep_rf_off: assert property (@(posedge ref_clk) disable iff (srst) // R1
        state == ST_SLEEP |-> !rx_ctrl.rf_enable && !rx_ctrl.osc_high_precision)
        else $error("rf section active in sleep");
    a_slave_needs_startup: assert property (@(posedge ref_clk) disable iff (srst) // R2
        $rose(rx_ctrl.slave_run) |-> $past(state) == ST_SLAVE_WAIT && $past(startup_done))
        else $error("slave run entered without start-up");
    a_mode_to_sleep: assert property (@(posedge ref_clk) disable iff (srst) // R3
        reg_wr.en && reg_wr.addr == ADDR_CHIP_MODE_CONTROL_0 && reg_wr.data[1:0] == 2'b00
        ##1 !reg_wr.en |=> state == ST_SLEEP)
        else $error("sleep not entered");
    a_mode_to_poll: assert property (@(posedge ref_clk) disable iff (srst) // R4
        state == ST_SLEEP && reg_wr.en && reg_wr.addr == ADDR_CHIP_MODE_CONTROL_0
        && reg_wr.data[0] ##1 !reg_wr.en |=> state == ST_SP_IDLE)
        else $error("self polling not entered");
    a_idle_holds: assert property (@(posedge ref_clk) disable iff (srst) // R12
        state == ST_SP_IDLE && !rx_run && operating_mode_select && !reg_wr.en
        |=> state == ST_SP_IDLE)
        else $error("idle left without receiver run");
    a_settle_before_search: assert property (@(posedge ref_clk) disable iff (srst) // R15
        state == ST_LOAD_CH |=> state == ST_SETTLE && settle_cnt == 14'(SETTLE_CYCLES_P - 1))
        else $error("settle wait not started");
    a_search_after_settle: assert property (@(posedge ref_clk) disable iff (srst) // R19
        $rose(rx_ctrl.search_active) |-> $past(state) == ST_SETTLE && $past(settle_cnt) == 0)
        else $error("search began before settling");
    a_store_channel: assert property (@(posedge ref_clk) disable iff (srst) // R17
        state == ST_STORE |=> actual_rf_channel[1:0] == $past(loop_cnt)
        && rx_ctrl.run_self_polling)
        else $error("channel not stored");
    a_compare_end: assert property (@(posedge ref_clk) disable iff (srst) // R18
        state == ST_COMPARE && at_last && !dual_config_enable && !reg_wr.en
        |=> state == ST_SP_IDLE)
        else $error("scan did not return to idle");
    a_loop_bound: assert property (@(posedge ref_clk) disable iff (srst) // R23
        state inside {ST_LOAD_CH, ST_SETTLE, ST_SEARCH} && !$past(reg_wr.en)
        |-> loop_cnt != 2'h0 && loop_cnt <= channel_count)
        else $error("loop counter out of range");

endmodule

// ### testbench/rps_host_model.sv
// Purpose: host model that writes and reads the sequencer registers
// Assumes: the strobe port takes a request at the rising edge after it is raised
// Notes: released address and data lines show the inverse of the last value
`timescale 1ns/1ps
module rps_host_model (
    input wire logic ref_clk,
    output rps_pkg::rps_reg_wr_t reg_wr,
    output logic rd_en,
    output logic [7:0] rd_addr,
    input wire logic [7:0] rd_data
);
    import rps_pkg::*;
    initial begin
        reg_wr = '0;
        rd_en = 1'b0;
        rd_addr = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= '{en: 1'b1, addr: a, data: d};
        @(posedge ref_clk);
        reg_wr <= '{en: 1'b0, addr: ~a, data: ~d};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        rd_en <= 1'b1;
        rd_addr <= a;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        rd_addr <= ~a;
        #1 d = rd_data;
    endtask
    task automatic enter_slave();
        wr(ADDR_CHIP_MODE_CONTROL_0, 8'h42);
    endtask
    // park in sleep first; an unparked scan could hang on new settings
    task automatic go_sleep();
        wr(ADDR_CHIP_MODE_CONTROL_0, 8'h40);
    endtask
endmodule

// ### testbench/test_receiver_mode_polling_sequencer.sv
// Purpose: self-checking bench of the mode and polling sequencer
// Assumes: settle count shortened to a few cycles
// Notes: polling timer, start-up and wake-up results are played by the bench
`timescale 1ns/1ps
module test_receiver_mode_polling_sequencer;
    import rps_pkg::*;
    localparam int N = 6;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    rps_reg_wr_t reg_wr;
    logic rd_en;
    logic [7:0] rd_addr, rd_data, v;
    logic rx_run = 1'b0, startup_done = 1'b0, wakeup_found = 1'b0, wakeup_miss = 1'b0;
    logic [1:0] pss = 2'b10;
    logic perm = 1'b1;
    rps_rx_ctrl_t rx_ctrl;
    rps_pll_cmd_t pll_cmd;
    logic cfg_init, modulation_fsk;
    logic [2:0] search_scheme;
    int num_errors = 0, tests_run = 0, cycles = 0;
    int inits = 0;
    always #2 ref_clk = ~ref_clk;
    // cfg_init is a one-cycle pulse, so it is counted rather than sampled late
    always @(posedge ref_clk) begin
        if (cfg_init === 1'b1) begin
            inits++;
        end
    end
    rps_sequencer #(.SETTLE_CYCLES_P(N)) u_dut (.ref_clk(ref_clk), .srst(srst),
        .reg_wr(reg_wr), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
        .rx_run(rx_run), .startup_done(startup_done), .polling_scheme_select(pss),
        .permanent_wakeup_search_enable(perm), .wakeup_found(wakeup_found),
        .wakeup_miss(wakeup_miss), .rx_ctrl(rx_ctrl), .pll_cmd(pll_cmd),
        .cfg_init(cfg_init), .modulation_fsk(modulation_fsk), .search_scheme(search_scheme));
    rps_host_model u_host (.ref_clk(ref_clk), .reg_wr(reg_wr), .rd_en(rd_en),
        .rd_addr(rd_addr), .rd_data(rd_data));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
            num_errors++;
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wait_load(input logic b, input logic [4:0] s);
        int k;
        k = 0;
        while (pll_cmd.load !== 1'b1 && k < 200) begin
            tick(1);
            k++;
        end
        chk({1'b0, pll_cmd.load, pll_cmd.cfg_b, pll_cmd.setting}, {2'b01, b, s});
    endtask
    // one scanned channel: load, settle time, search scheme, then the result
    task automatic channel(input logic b, input logic [4:0] s, input logic hit);
        int k;
        wait_load(b, s);
        k = 0;
        while (rx_ctrl.search_active !== 1'b1 && k < 200) begin
            tick(1);
            k++;
        end
        chk(k[7:0], N[7:0]);
        chk({5'b0, search_scheme}, {5'b0, perm, pss});
        @(posedge ref_clk);
        wakeup_found <= hit;
        wakeup_miss <= !hit;
        @(posedge ref_clk);
        wakeup_found <= 1'b0;
        wakeup_miss <= 1'b0;
        #1;
    endtask
    task automatic start_scan();
        int k;
        k = 0;
        @(posedge ref_clk);
        rx_run <= 1'b1;
        startup_done <= 1'b0;
        tick(0);
        while (rx_ctrl.startup_req !== 1'b1 && k < 50) begin
            tick(1);
            k++;
        end
        chk({7'b0, rx_ctrl.startup_req}, 8'h01);
        // the sequencer must keep waiting while start-up is still busy
        tick(2);
        chk({6'b0, rx_ctrl.startup_req, rx_ctrl.search_active}, 8'h02);
        @(posedge ref_clk);
        rx_run <= 1'b0;
        startup_done <= 1'b1;
        #1;
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            stop_test();
        end
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge ref_clk);
        srst <= 1'b0;
        tick(1);
        chk({6'b0, rx_ctrl.rf_enable, rx_ctrl.osc_high_precision}, 8'h00);
        u_host.rd(ADDR_ACTUAL_RF_CHANNEL, v);
        chk(v, RST_ACTUAL_RF_CHANNEL);
        u_host.rd(ADDR_CONFIG_A_MODULATION_TYPE, v);
        chk(v, 8'h00);
        u_host.rd(8'h7F, v);
        chk(v, 8'h00);
        // configuration written in sleep
        u_host.wr(ADDR_CONFIG_A_MODULATION_TYPE, 8'h0E);
        u_host.wr(ADDR_CONFIG_A_CHANNEL1_PLL, 8'h11);
        u_host.wr(ADDR_CONFIG_A_CHANNEL1_PLL + 8'h01, 8'h12);
        u_host.wr(ADDR_CONFIG_A_CHANNEL1_PLL + 8'h02, 8'h13);
        u_host.enter_slave();
        tick(3);
        chk({6'b0, rx_ctrl.startup_req, rx_ctrl.slave_run}, 8'h02);
        @(posedge ref_clk);
        startup_done <= 1'b1;
        wait_load(1'b0, 5'h11);
        tick(2);
        chk({5'b0, rx_ctrl.slave_run, rx_ctrl.rf_enable, modulation_fsk}, 8'h06);
        u_host.go_sleep();
        tick(3);
        chk({6'b0, rx_ctrl.rf_enable, rx_ctrl.osc_high_precision}, 8'h00);
        // single configuration, three channels, all missed
        u_host.wr(ADDR_CHIP_MODE_CONTROL_0, 8'h41);
        start_scan();
        channel(1'b0, 5'h11, 1'b0);
        chk({7'b0, modulation_fsk}, 8'h01);
        channel(1'b0, 5'h12, 1'b0);
        channel(1'b0, 5'h13, 1'b0);
        tick(3);
        chk({7'b0, rx_ctrl.rf_enable}, 8'h00);
        chk(inits[7:0], 8'h01);
        // dual configuration: A then B, then idle
        u_host.go_sleep();
        u_host.wr(ADDR_CONFIG_B_MODULATION_TYPE, 8'h04);
        u_host.wr(ADDR_CONFIG_B_CHANNEL1_PLL, 8'h15);
        u_host.wr(ADDR_CHIP_MODE_CONTROL_0, 8'h45);
        start_scan();
        channel(1'b0, 5'h11, 1'b0);
        channel(1'b0, 5'h12, 1'b0);
        channel(1'b0, 5'h13, 1'b0);
        channel(1'b1, 5'h15, 1'b0);
        chk({7'b0, modulation_fsk}, 8'h00);
        tick(3);
        chk({7'b0, rx_ctrl.rf_enable}, 8'h00);
        chk(inits[7:0], 8'h03);
        // wake-up on the second of two channels
        u_host.go_sleep();
        // a second search scheme, so the latch is seen to follow its inputs
        pss <= 2'b01;
        perm <= 1'b0;
        u_host.wr(ADDR_CONFIG_A_MODULATION_TYPE, 8'h0A);
        u_host.wr(ADDR_CHIP_MODE_CONTROL_0, 8'h41);
        start_scan();
        channel(1'b0, 5'h11, 1'b0);
        channel(1'b0, 5'h12, 1'b1);
        tick(3);
        chk({6'b0, rx_ctrl.run_self_polling, modulation_fsk}, 8'h02);
        u_host.rd(ADDR_ACTUAL_RF_CHANNEL, v);
        chk(v, 8'h02);
        chk(inits[7:0], 8'h04);
        stop_test();
    end
endmodule
